// File: rtl/rll_ctrl.sv
// remote/local/lockout state control and host command intake
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - serial frame is 9600 baud, 8 data bits, 1 stop, no parity only.
// - Xon/Xoff flow control on serial; each command line ends in CR.
// - exactly one host interface active, serial or bus, from setup.
// - bus address settable 0 through 30; other values never match.
// - on the bus we are talker/listener, never system controller.
// - local state honours panel keys and processes every host command.
// - serial REMOTE or REN with listen address enters remote; show indicator.
// - remote ignores keys but local; local key, LOCAL or GTL return local.
// - LOCKOUT or LLO locks: local to local-lock, remote to remote-lock.
// - remote-lock ignores every panel key; indicator shown.
// - local-lock is local, but remote request goes to remote-lock.
// - GTL moves remote-lock to local-lock.
// - REN false returns lock states to local; serial LOCAL too.
// - serial words stand for GTL, GTR, LLO; nothing else emulated.
// - on the bus only interface lines control mode, never text words.
// - lower-case letters are folded to upper case before processing.
module rll_ctrl
    import rll_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    // setup choices
    input wire logic if_sel_bus,
    input wire logic [4:0] bus_addr_set,
    // serial line
    input wire logic rxd,
    output logic xoff_req_r,
    output logic tx_pause_r,
    // bus interface messages and data
    input wire logic ren,
    input wire logic mla_stb,
    input wire logic [4:0] mla_addr,
    input wire logic gtl_stb,
    input wire logic llo_stb,
    input wire logic [7:0] bus_byte,
    input wire logic bus_byte_stb,
    output logic bus_hold_r,
    output logic atn_oe_r,
    output logic ren_oe_r,
    // front panel
    input wire logic key_stb,
    input wire logic [7:0] key_code,
    input wire logic key_is_local,
    output logic key_out_stb_r,
    output logic [7:0] key_out_code_r,
    // host command stream
    output logic [7:0] cmd_byte_r,
    output logic cmd_valid_r,
    input wire logic cmd_ready,
    // status
    output logic rem_indicator_r,
    output logic lockout_r,
    output logic rx_overrun_r,
    output logic rx_frame_err_r
);
    logic rst_meta_r;
    logic rst_n;
    rll_state_type state_r;
    rll_state_type state_nxt;
    logic [WORD_W-1:0] word_r;
    logic [3:0] len_r;
    logic hit_local_r;
    logic hit_remote_r;
    logic hit_lock_r;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_ferr;
    logic [7:0] f_data;
    logic f_valid;
    logic f_in_ready;
    logic [$clog2(FIFO_D):0] f_level;

    // reset released through two flops
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    rll_uart_rx u_rx (
        .clk(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .rxd(rxd),
        .data(rx_data),
        .valid(rx_valid),
        .frame_err(rx_ferr)
    );

    // one source feeds the fifo, picked by setup
    wire ser_sel = ~if_sel_bus;
    wire [7:0] f_in_data = if_sel_bus ? bus_byte : rx_data;
    wire f_in_valid = if_sel_bus ? bus_byte_stb : rx_valid;

    // drain stalls while the host stream holds an unread byte
    wire f_take_rdy = ~cmd_valid_r | cmd_ready;

    rll_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
        .clk(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .in_data(f_in_data),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(f_take_rdy),
        .level(f_level)
    );

    wire f_take = ce & f_valid & f_take_rdy;
    wire [7:0] ch = rll_upcase(f_data);
    wire is_flow = ser_sel & (ch == CH_XON || ch == CH_XOFF);
    wire is_eol = (ch == CH_CR);
    // words only count on serial; bus text is plain data
    wire word_en = ser_sel & is_eol;
    wire m_local = word_en & len_r == LEN_LOCAL & word_r == WORD_LOCAL;
    wire m_remote = word_en & len_r == LEN_REMOTE & word_r == WORD_REMOTE;
    wire m_lock = word_en & len_r == LEN_LOCKOUT & word_r == WORD_LOCKOUT;

    // line buffer keeps the last seven upper-case characters
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            word_r <= '0;
            len_r <= '0;
        end
        else if (f_take && !is_flow)
        begin
            word_r <= is_eol ? '0 : {word_r[WORD_W-9:0], ch};
            len_r <= is_eol ? '0 : (len_r == LEN_MAX) ? len_r : len_r + 1'b1;
        end
    end

    // matched serial words become one-cycle requests
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hit_local_r <= 1'b0;
            hit_remote_r <= 1'b0;
            hit_lock_r <= 1'b0;
        end
        else if (ce)
        begin
            hit_local_r <= f_take & m_local;
            hit_remote_r <= f_take & m_remote;
            hit_lock_r <= f_take & m_lock;
        end
    end

    // every non-flow byte goes on to the command parser, in any state
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_byte_r <= '0;
            cmd_valid_r <= 1'b0;
        end
        else if (ce)
        begin
            if (f_take && !is_flow)
            begin
                cmd_byte_r <= ch;
                cmd_valid_r <= 1'b1;
            end
            else if (cmd_ready)
                cmd_valid_r <= 1'b0;
        end
    end

    // transition requests, gated by the selected interface
    wire addr_ok = (bus_addr_set <= ADDR_MAX);
    wire bus_remote = if_sel_bus & ren & mla_stb & addr_ok &
        (mla_addr == bus_addr_set);
    wire bus_gtl = if_sel_bus & gtl_stb;
    wire bus_llo = if_sel_bus & llo_stb;
    wire ren_low = if_sel_bus & ~ren;
    wire ser_local = ser_sel & hit_local_r;
    wire ser_remote = ser_sel & hit_remote_r;
    wire ser_lock = ser_sel & hit_lock_r;
    wire local_key = key_stb & key_is_local;
    wire req_lock = ser_lock | bus_llo;
    wire req_remote = ser_remote | bus_remote;

    // next operating state
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_LOC:
            begin
                if (req_lock)
                    state_nxt = ST_LWL;
                else if (req_remote)
                    state_nxt = ST_REM;
            end
            ST_REM:
            begin
                if (ren_low || ser_local || bus_gtl || local_key)
                    state_nxt = ST_LOC;
                else if (req_lock)
                    state_nxt = ST_RWL;
            end
            ST_LWL:
            begin
                if (ren_low || ser_local)
                    state_nxt = ST_LOC;
                else if (req_remote)
                    state_nxt = ST_RWL;
            end
            ST_RWL:
            begin
                if (ren_low || ser_local)
                    state_nxt = ST_LOC;
                else if (bus_gtl)
                    state_nxt = ST_LWL;
            end
        endcase
    end

    // panel keys pass only in the two local states
    wire key_pass = key_stb & (state_r == ST_LOC || state_r == ST_LWL);

    // state and derived indicators
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= ST_LOC;
            rem_indicator_r <= 1'b0;
            lockout_r <= 1'b0;
            key_out_stb_r <= 1'b0;
            key_out_code_r <= '0;
        end
        else if (ce)
        begin
            state_r <= state_nxt;
            rem_indicator_r <= (state_nxt == ST_REM || state_nxt == ST_RWL);
            lockout_r <= (state_nxt == ST_LWL || state_nxt == ST_RWL);
            key_out_stb_r <= key_pass;
            if (key_pass)
                key_out_code_r <= key_code;
        end
    end

    // flow: hysteresis on fill level; host pause from its own Xoff
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            xoff_req_r <= 1'b0;
            bus_hold_r <= 1'b0;
            tx_pause_r <= 1'b0;
            rx_overrun_r <= 1'b0;
            rx_frame_err_r <= 1'b0;
            atn_oe_r <= 1'b0;
            ren_oe_r <= 1'b0;
        end
        else if (ce)
        begin
            if (f_level >= ($clog2(FIFO_D)+1)'(FIFO_HI))
                xoff_req_r <= ser_sel;
            else if (f_level <= ($clog2(FIFO_D)+1)'(FIFO_LO))
                xoff_req_r <= 1'b0;
            bus_hold_r <= if_sel_bus & ~f_in_ready;
            if (f_take && is_flow)
                tx_pause_r <= (ch == CH_XOFF);
            // a byte lost to a full fifo stays flagged until reset
            if (f_in_valid && !f_in_ready)
                rx_overrun_r <= 1'b1;
            if (rx_ferr && ser_sel)
                rx_frame_err_r <= 1'b1;
            atn_oe_r <= 1'b0;
            ren_oe_r <= 1'b0;
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_serial_remote;
        ce && state_r == ST_LOC && ser_remote && !req_lock;
    endsequence
    sequence s_rwl_gtl;
        ce && state_r == ST_RWL && bus_gtl && !ren_low && !ser_local;
    endsequence

    a_serial_remote: assert property (s_serial_remote |=>
        state_r == ST_REM ##0 rem_indicator_r)
        else $error("serial remote did not enter remote");
    a_lock_local: assert property (ce && state_r == ST_LOC && req_lock
        |=> state_r == ST_LWL && lockout_r)
        else $error("lock from local missed");
    a_rwl_keys: assert property (ce && state_r == ST_RWL
        |=> !key_out_stb_r)
        else $error("key passed in remote lockout");
    a_gtl_rwl: assert property (s_rwl_gtl |=> state_r == ST_LWL)
        else $error("gtl from remote lockout wrong");
    a_ren_drop: assert property (ce && ren_low && state_r != ST_LOC
        |=> state_r == ST_LOC && !rem_indicator_r)
        else $error("ren false did not return local");
    a_local_key: assert property (ce && state_r == ST_REM && local_key
        |=> state_r == ST_LOC ##0 !key_out_stb_r)
        else $error("local key in remote wrong");
    a_lwl_remote: assert property (ce && state_r == ST_LWL
        && req_remote && !ren_low && !ser_local |=> state_r == ST_RWL)
        else $error("remote from local lockout wrong");
    a_upcase_out: assert property (cmd_valid_r |->
        !(cmd_byte_r >= CH_LOW_A && cmd_byte_r <= CH_LOW_Z))
        else $error("lower case reached command stream");
    a_addr_range: assert property (ce && if_sel_bus
        && state_r == ST_LOC && bus_addr_set > ADDR_MAX
        |=> !rem_indicator_r)
        else $error("remote taken at illegal address");
    a_never_ctrl: assert property (!atn_oe_r && !ren_oe_r)
        else $error("controller line driven");
    a_local_keys: assert property (ce && state_r == ST_LOC && key_stb
        |=> key_out_stb_r && key_out_code_r == $past(key_code))
        else $error("local key not honoured");
    a_sel_gate: assert property (ce && if_sel_bus && state_r == ST_LOC
        && !bus_remote && !bus_llo |=> state_r == ST_LOC)
        else $error("serial word acted while bus selected");
endmodule
`default_nettype wire

// File: rtl/rll_pkg.sv
// shared constants for the remote/local lockout control block
package rll_pkg;
    // clock and serial frame timing
    localparam int CLK_HZ = 25000000;
    localparam int BAUD_RATE = 9600;
    localparam int BIT_CYC = CLK_HZ / BAUD_RATE;
    localparam int HALF_CYC = BIT_CYC / 2;
    localparam int DATA_BITS = 8;
    localparam int STOP_BITS = 1;
    // character codes seen by the interpreter
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_XON = 8'h11;
    localparam logic [7:0] CH_XOFF = 8'h13;
    localparam logic [7:0] CH_LOW_A = 8'h61;
    localparam logic [7:0] CH_LOW_Z = 8'h7a;
    localparam logic [7:0] CH_CASE = 8'h20;
    // serial-only words, right aligned in the line buffer
    localparam int WORD_W = 56;
    localparam logic [55:0] WORD_LOCAL = 56'h00_00_4c_4f_43_41_4c;
    localparam logic [55:0] WORD_REMOTE = 56'h00_52_45_4d_4f_54_45;
    localparam logic [55:0] WORD_LOCKOUT = 56'h4c_4f_43_4b_4f_55_54;
    localparam logic [3:0] LEN_LOCAL = 4'h5;
    localparam logic [3:0] LEN_REMOTE = 4'h6;
    localparam logic [3:0] LEN_LOCKOUT = 4'h7;
    localparam logic [3:0] LEN_MAX = 4'h8;
    // bus address range
    localparam logic [4:0] ADDR_MAX = 5'h1e;
    // fifo
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 32;
    localparam int FIFO_HI = 24;
    localparam int FIFO_LO = 8;
    // operating states, one-hot
    typedef enum logic [3:0] {
        ST_LOC = 4'h1,
        ST_LWL = 4'h2,
        ST_REM = 4'h4,
        ST_RWL = 4'h8
    } rll_state_type;
    // fold lower-case letters onto upper case
    function automatic logic [7:0] rll_upcase(input logic [7:0] c);
        if (c >= CH_LOW_A && c <= CH_LOW_Z)
            return c & ~CH_CASE;
        return c;
    endfunction
endpackage

// File: rtl/rll_fifo.sv
// synchronous flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module rll_fifo
    import rll_pkg::*;
#(
    parameter int W = FIFO_W,
    parameter int D = FIFO_D
)(
    // clocking
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // fill side
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // drain side
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    // fill level
    output logic [$clog2(D):0] level
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_r [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    wire push = ce & in_valid & in_ready;
    wire pop = ce & out_valid & out_ready;

    // full and empty come straight from the count
    assign in_ready = (cnt_r != (AW+1)'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign level = cnt_r;

    // storage is not reset; only pointers matter
    always_ff @(posedge clk)
    begin
        if (push)
            mem_r[wp_r] <= in_data;
    end

    // pointer and count update
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
            if (pop)
                rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
            if (push != pop)
                cnt_r <= push ? cnt_r + 1'b1 : cnt_r - 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: rtl/rll_uart_rx.sv
// serial receiver for the fixed 8N1 frame
`timescale 1ns/100ps
`default_nettype none
module rll_uart_rx
    import rll_pkg::*;
(
    // clocking
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // line
    input wire logic rxd,
    // received byte
    output logic [7:0] data,
    output logic valid,
    output logic frame_err
);
    logic busy_r;
    logic [11:0] tick_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic valid_r;
    logic ferr_r;
    wire tick_end = (tick_r == '0);

    assign data = sh_r;
    assign valid = valid_r;
    assign frame_err = ferr_r;

    // sample mid-bit; start bit re-checked to reject glitches
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_r <= 1'b0;
            tick_r <= '0;
            bit_r <= '0;
            sh_r <= '0;
            valid_r <= 1'b0;
            ferr_r <= 1'b0;
        end
        else if (ce)
        begin
            valid_r <= 1'b0;
            ferr_r <= 1'b0;
            if (!busy_r)
            begin
                if (!rxd)
                begin
                    busy_r <= 1'b1;
                    tick_r <= 12'(HALF_CYC);
                    bit_r <= '0;
                end
            end
            else if (!tick_end)
                tick_r <= tick_r - 1'b1;
            else
            begin
                tick_r <= 12'(BIT_CYC - 1);
                bit_r <= bit_r + 1'b1;
                if (bit_r == '0 && rxd)
                    busy_r <= 1'b0;
                else if (bit_r >= 4'h1 && bit_r <= 4'(DATA_BITS))
                    sh_r <= {rxd, sh_r[7:1]};
                else if (bit_r == 4'(DATA_BITS + STOP_BITS))
                begin
                    busy_r <= 1'b0;
                    valid_r <= rxd;
                    ferr_r <= ~rxd;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: testbench/rll_host_model.sv
// serial host model: sends 8N1 characters toward the device
`timescale 1ns/100ps
`default_nettype none
module rll_host_model
    import rll_pkg::*;
(
    // clocking
    input wire logic clk,
    // serial line toward the device
    output logic rxd
);
    // line idles high between frames, as a real idle transmitter does
    initial rxd = 1'b1;

    // start bit, eight data bits lsb first, one stop bit, no parity
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(negedge clk);
            rxd = frame[i];
            repeat (BIT_CYC - 1) @(negedge clk);
        end
    endtask

    // flow control and line end are plain characters on the wire
    task automatic send_xoff();
        send_byte(CH_XOFF);
    endtask

    task automatic send_eol();
        send_byte(CH_CR);
    endtask
endmodule
`default_nettype wire

// File: testbench/test_remote_local_lockout_control.sv
// self-checking bench for the remote/local lockout control block
`timescale 1ns/100ps
`default_nettype none
module test_remote_local_lockout_control
    import rll_pkg::*;
;
    logic clk_sys = 1'b0;
    logic nrst, ce, if_sel_bus, rxd, ren, mla_stb, gtl_stb, llo_stb;
    logic bus_byte_stb, key_stb, key_is_local, cmd_ready;
    logic [4:0] bus_addr_set, mla_addr;
    logic [7:0] bus_byte, key_code, cmd_byte_r, key_out_code_r;
    logic xoff_req_r, tx_pause_r, bus_hold_r, atn_oe_r, ren_oe_r;
    logic key_out_stb_r, cmd_valid_r, rem_indicator_r, lockout_r;
    logic rx_overrun_r, rx_frame_err_r;
    logic [7:0] rxq[$];
    logic [7:0] exp_b;
    int fail_count = 0;
    int checks_done = 0;
    logic [7:0] word_b[7] = '{8'h72, 8'h65, 8'h6d, 8'h6f, 8'h74, 8'h65, 8'h0d};

    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;

    rll_host_model host_u (.clk(clk_sys), .rxd(rxd));

    rll_ctrl dut_u (
        .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .if_sel_bus(if_sel_bus),
        .bus_addr_set(bus_addr_set), .rxd(rxd), .xoff_req_r(xoff_req_r),
        .tx_pause_r(tx_pause_r), .ren(ren), .mla_stb(mla_stb),
        .mla_addr(mla_addr), .gtl_stb(gtl_stb), .llo_stb(llo_stb),
        .bus_byte(bus_byte), .bus_byte_stb(bus_byte_stb),
        .bus_hold_r(bus_hold_r), .atn_oe_r(atn_oe_r), .ren_oe_r(ren_oe_r),
        .key_stb(key_stb), .key_code(key_code), .key_is_local(key_is_local),
        .key_out_stb_r(key_out_stb_r), .key_out_code_r(key_out_code_r),
        .cmd_byte_r(cmd_byte_r), .cmd_valid_r(cmd_valid_r),
        .cmd_ready(cmd_ready), .rem_indicator_r(rem_indicator_r),
        .lockout_r(lockout_r), .rx_overrun_r(rx_overrun_r),
        .rx_frame_err_r(rx_frame_err_r)
    );

    // collect every command byte the drain side accepts
    always @(posedge clk_sys)
        if (cmd_valid_r === 1'b1 && cmd_ready === 1'b1)
            rxq.push_back(cmd_byte_r);

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic st(input string what, input logic rem, input logic lk);
        chk(what, {6'h00, rem_indicator_r, lockout_r}, {6'h00, rem, lk});
    endtask

    // one-cycle event: 0 listen addr, 1 gtl, 2 llo, 3 key, 4 local key,
    // 5 bus data byte; ends one negedge after the taking edge
    task automatic evt(input int k, input logic [7:0] v);
        @(negedge clk_sys);
        mla_addr = v[4:0];
        key_code = v;
        bus_byte = v;
        mla_stb = (k == 0);
        gtl_stb = (k == 1);
        llo_stb = (k == 2);
        key_stb = (k == 3 || k == 4);
        key_is_local = (k == 4);
        bus_byte_stb = (k == 5);
        @(negedge clk_sys);
        {mla_stb, gtl_stb, llo_stb, key_stb, key_is_local, bus_byte_stb} = '0;
    endtask

    // stage a line on the bus while the drain stalls, then drain it with
    // serial selected: the serial word path runs without the slow uart;
    // the leading line end clears whatever the word buffer held
    task automatic ser_word(input string s);
        if_sel_bus = 1'b1;
        cmd_ready = 1'b0;
        evt(5, CH_CR);
        for (int i = 0; i < s.len(); i++)
            evt(5, s[i]);
        evt(5, CH_CR);
        if_sel_bus = 1'b0;
        cmd_ready = 1'b1;
        repeat (20) @(negedge clk_sys);
    endtask

    task automatic report_and_stop();
        if (fail_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // watchdog: three serial characters dominate the run time
    initial
    begin
        #(100000 * 40);
        fail_count++;
        report_and_stop();
    end

    initial
    begin
        {mla_stb, gtl_stb, llo_stb, key_stb, key_is_local, bus_byte_stb} = '0;
        nrst = 1'b0;
        ce = 1'b1;
        if_sel_bus = 1'b1;
        bus_addr_set = 5'h05;
        ren = 1'b0;
        cmd_ready = 1'b1;
        mla_addr = 5'h00;
        key_code = 8'h00;
        bus_byte = 8'h00;
        repeat (2) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        st("reset state", 1'b0, 1'b0);
        chk("controller drive", {6'h00, atn_oe_r, ren_oe_r}, 8'h00);
        evt(3, 8'h31);
        chk("local key pass", {7'h00, key_out_stb_r}, 8'h01);
        chk("local key code", key_out_code_r, 8'h31);
        ren = 1'b1;
        evt(0, 8'h06);
        st("foreign address", 1'b0, 1'b0);
        evt(0, 8'h05);
        st("listen remote", 1'b1, 1'b0);
        evt(3, 8'h32);
        chk("remote key blocked", {7'h00, key_out_stb_r}, 8'h00);
        evt(4, 8'h30);
        st("local key return", 1'b0, 1'b0);
        evt(0, 8'h05);
        evt(1, 8'h00);
        st("gtl return", 1'b0, 1'b0);
        evt(2, 8'h00);
        st("lock from local", 1'b0, 1'b1);
        evt(0, 8'h05);
        st("locked remote req", 1'b1, 1'b1);
        evt(4, 8'h30);
        st("locked local key", 1'b1, 1'b1);
        chk("locked key out", {7'h00, key_out_stb_r}, 8'h00);
        evt(1, 8'h00);
        st("gtl to local lock", 1'b0, 1'b1);
        ren = 1'b0;
        @(negedge clk_sys);
        st("ren false local lock", 1'b0, 1'b0);
        ren = 1'b1;
        evt(0, 8'h05);
        evt(2, 8'h00);
        st("lock from remote", 1'b1, 1'b1);
        ren = 1'b0;
        @(negedge clk_sys);
        st("ren false remote lock", 1'b0, 1'b0);
        ren = 1'b1;
        bus_addr_set = 5'h1e;
        evt(0, 8'h1e);
        st("top address", 1'b1, 1'b0);
        evt(1, 8'h00);
        bus_addr_set = 5'h1f;
        evt(0, 8'h1f);
        st("address 31", 1'b0, 1'b0);
        // textual word over the bus travels as data only
        rxq.delete();
        foreach (word_b[i])
            evt(5, word_b[i]);
        repeat (10) @(negedge clk_sys);
        chk("bus word count", 8'(rxq.size()), 8'h07);
        foreach (word_b[i])
        begin
            exp_b = word_b[i];
            if (exp_b >= 8'h61 && exp_b <= 8'h7a)
                exp_b = exp_b - 8'h20;
            chk("bus byte folded", rxq[i], exp_b);
        end
        st("bus word inert", 1'b0, 1'b0);
        // fill the buffer past full while the drain stalls, then empty it
        rxq.delete();
        cmd_ready = 1'b0;
        for (int i = 0; i < 40; i++)
            evt(5, 8'h40 + i[7:0]);
        chk("bus hold at full", {7'h00, bus_hold_r}, 8'h01);
        chk("overrun flag", {7'h00, rx_overrun_r}, 8'h01);
        chk("no xoff on bus", {7'h00, xoff_req_r}, 8'h00);
        if_sel_bus = 1'b0;
        @(negedge clk_sys);
        chk("xoff at high mark", {7'h00, xoff_req_r}, 8'h01);
        if_sel_bus = 1'b1;
        cmd_ready = 1'b1;
        repeat (60) @(negedge clk_sys);
        chk("hold released", {7'h00, bus_hold_r}, 8'h00);
        chk("kept count", 8'(rxq.size()), 8'h21);
        foreach (rxq[i])
            chk("kept order", rxq[i], 8'h40 + i[7:0]);
        // serial words, staged through the buffer, any letter case
        ser_word("remote");
        st("serial remote", 1'b1, 1'b0);
        ser_word("Local");
        st("serial local", 1'b0, 1'b0);
        ser_word("lockout");
        st("serial lockout", 1'b0, 1'b1);
        ser_word("REMOTE");
        st("serial locked remote", 1'b1, 1'b1);
        ser_word("local");
        st("serial local from lock", 1'b0, 1'b0);
        // serial selected: bus messages no longer count
        if_sel_bus = 1'b0;
        evt(2, 8'h00);
        st("bus ignored", 1'b0, 1'b0);
        rxq.delete();
        host_u.send_byte(8'h7a);
        host_u.send_eol();
        host_u.send_xoff();
        repeat (20) @(negedge clk_sys);
        chk("serial count", 8'(rxq.size()), 8'h02);
        chk("serial folded", rxq[0], 8'h5a);
        chk("serial line end", rxq[1], CH_CR);
        chk("host paused", {7'h00, tx_pause_r}, 8'h01);
        chk("frame clean", {7'h00, rx_frame_err_r}, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
